/* File: asrm_pkg.sv */
/*
  Package for the asynchronous static memory controller: timing figures,
  derived cycle counts, widths and the state enumeration.
  Assumes a single 50 MHz system clock.
*/
package asrm_pkg;

  // ********************
  // widths
  // ********************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // ********************
  // timing in ns and clock
  // ********************
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_CYCLE_MIN_NS = 15;
  localparam int T_WRITE_PULSE_MIN_NS = 12;
  localparam int T_ADDR_TO_END_MIN_NS = 12;
  localparam int T_DATA_TO_END_MIN_NS = 7;
  localparam int T_ACCESS_MAX_NS = 15;
  localparam int T_OE_ACCESS_MAX_NS = 8;
  localparam int T_OUT_OFF_MAX_NS = 8;
  localparam int T_WE_OFF_MAX_NS = 7;

  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  // ********************
  // derived cycle counts
  // ********************
  localparam int WR_PULSE_CYC = ceil_cyc(T_WRITE_PULSE_MIN_NS);
  localparam int RD_WAIT_CYC = ceil_cyc(T_ACCESS_MAX_NS);
  localparam int TURN_CYC = ceil_cyc(T_OUT_OFF_MAX_NS);
  localparam int CYC_MIN_CYC = ceil_cyc(T_CYCLE_MIN_NS);
  localparam int CNT_W = 4;

  typedef enum logic [2:0] {
    ASRM_IDLE,
    ASRM_RD_ACCESS,
    ASRM_RD_DONE,
    ASRM_WR_PULSE,
    ASRM_WR_END,
    ASRM_TURN
  } asrm_state_t;

endpackage : asrm_pkg

/* File: asrm_req_if.sv */
/*
  Request and answer bundle between the controller core and its timer.
  Assumes both ends share mclk.
*/
`timescale 1ns/100ps
interface asrm_req_if;
  import asrm_pkg::*;
  logic load;
  logic [CNT_W-1:0] count;
  logic done;
  modport core (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface : asrm_req_if

/* File: asrm_timer.sv */
/*
  Down counter that measures pin intervals in whole clock cycles.
  Assumes load is a one-cycle pulse from the controller core.
*/
`timescale 1ns/100ps
module asrm_timer (
  input wire logic mclk,
  input wire logic sys_rst,
  asrm_req_if.timer tmr
);
  import asrm_pkg::*;

  logic [CNT_W-1:0] remain;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      remain <= '0;
    end else if (tmr.load) begin
      remain <= tmr.count;
    end else if (remain != '0) begin
      remain <= remain - 4'h1;
    end
  end

  // done during the last counted cycle, and while idle with no load
  assign tmr.done = (remain == 4'h1) || ((remain == '0) && !tmr.load);

endmodule : asrm_timer

/* File: asrm_ctrl.sv */
/*
  Controller driving an asynchronous 32K x 8 static memory by its pins.
  One read or write request at a time; the memory sits outside.
  Assumes the memory data pins are resolved outside from oe.
  Assumes every cycle parameter is at least 1 and fits the timer width.
*/
`timescale 1ns/100ps
module asrm_ctrl #(
  parameter int WR_CYC = asrm_pkg::WR_PULSE_CYC,
  parameter int RD_CYC = asrm_pkg::RD_WAIT_CYC,
  parameter int TA_CYC = asrm_pkg::TURN_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [asrm_pkg::ADDR_W-1:0] req_addr,
  input wire logic [asrm_pkg::DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asrm_pkg::DATA_W-1:0] rsp_rdata,
  output logic [asrm_pkg::ADDR_W-1:0] word_address,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic write_en_n,
  input wire logic [asrm_pkg::DATA_W-1:0] byte_data_bus_i,
  output logic [asrm_pkg::DATA_W-1:0] byte_data_bus_o,
  output logic byte_data_bus_oe
);
  import asrm_pkg::*;

  asrm_state_t state;
  asrm_state_t next_state;
  asrm_req_if tif ();

  asrm_timer u_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tmr(tif)
  );

  // ********************
  // sequencing
  // ********************
  // every phase lasts at least one full 20 ns cycle, so the 15 ns cycle
  // time and the 0 ns setup and hold figures are met with margin
  always_comb begin
    next_state = state;
    tif.load = 1'b0;
    tif.count = '0;
    unique case (state)
      ASRM_IDLE: begin
        if (req_valid) begin
          tif.load = 1'b1;
          if (req_write) begin
            tif.count = CNT_W'(WR_CYC);
            next_state = ASRM_WR_PULSE;
          end else begin
            tif.count = CNT_W'(RD_CYC);
            next_state = ASRM_RD_ACCESS;
          end
        end
      end
      ASRM_RD_ACCESS: begin
        if (tif.done) begin
          next_state = ASRM_RD_DONE;
        end
      end
      ASRM_RD_DONE: begin
        // memory may still drive for up to 8 ns after release
        tif.load = 1'b1;
        tif.count = CNT_W'(TA_CYC);
        next_state = ASRM_TURN;
      end
      ASRM_WR_PULSE: begin
        if (tif.done) begin
          next_state = ASRM_WR_END;
        end
      end
      ASRM_WR_END: begin
        tif.load = 1'b1;
        tif.count = CNT_W'(TA_CYC);
        next_state = ASRM_TURN;
      end
      ASRM_TURN: begin
        if (tif.done) begin
          next_state = ASRM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ASRM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign req_ready = (state == ASRM_IDLE);

  // ********************
  // pins
  // ********************
  // address and data are latched at acceptance and stay put until the
  // next request, so they are stable across the whole select window
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      word_address <= '0;
      byte_data_bus_o <= '0;
    end else if (state == ASRM_IDLE && req_valid) begin
      word_address <= req_addr;
      byte_data_bus_o <= req_wdata;
    end
  end

  // select frames the whole access, the write end cycle included, so a
  // write is always ended by write enable and never by select
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chip_sel_n <= 1'b1;
    end else begin
      unique case (next_state)
        ASRM_RD_ACCESS, ASRM_WR_PULSE, ASRM_WR_END: begin
          chip_sel_n <= 1'b0;
        end
        default: begin
          chip_sel_n <= 1'b1;
        end
      endcase
    end
  end

  // output enable and write enable never fall together, so the memory
  // outputs stay off through every write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_en_n <= 1'b1;
      write_en_n <= 1'b1;
    end else begin
      unique case (next_state)
        ASRM_RD_ACCESS: begin
          out_en_n <= 1'b0;
          write_en_n <= 1'b1;
        end
        ASRM_WR_PULSE: begin
          out_en_n <= 1'b1;
          write_en_n <= 1'b0;
        end
        ASRM_WR_END: begin
          // write ends here while select is still low
          out_en_n <= 1'b1;
          write_en_n <= 1'b1;
        end
        default: begin
          out_en_n <= 1'b1;
          write_en_n <= 1'b1;
        end
      endcase
    end
  end

  // a read leaves the memory driving for up to 8 ns after release; the
  // turnaround state keeps the controller off the pins a full cycle more
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      byte_data_bus_oe <= 1'b0;
    end else begin
      unique case (next_state)
        ASRM_WR_PULSE, ASRM_WR_END: begin
          byte_data_bus_oe <= 1'b1;
        end
        default: begin
          byte_data_bus_oe <= 1'b0;
        end
      endcase
    end
  end

  // ********************
  // read answer
  // ********************
  // sampled at the end of the access wait, well past 15 ns; slower grades
  // are handled by raising the cycle parameters
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == ASRM_RD_ACCESS && tif.done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= byte_data_bus_i;
      end
    end
  end

endmodule : asrm_ctrl

/* File: asrm_properties.sv */
/*
  Pin checker for the static memory controller.
  Assumes binding into asrm_ctrl, single mclk domain.
*/
`timescale 1ns/100ps
module asrm_properties #(
  parameter int WR_CYC = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  input wire logic [14:0] word_address,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic [7:0] byte_data_bus_i,
  input wire logic [7:0] byte_data_bus_o,
  input wire logic byte_data_bus_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic [3:0] we_lo;
  always_ff @(posedge mclk) begin
    if (sys_rst || write_en_n) we_lo <= 4'h0;
    else we_lo <= we_lo + 4'h1;
  end
  sequence s_rd_take;
    req_valid && req_ready && !req_write;
  endsequence
  sequence s_wr_busy;
    !req_ready [*3] ##1 req_ready;
  endsequence
  chk_we_read_high: assert property (!chip_sel_n && !out_en_n |-> write_en_n)
    else $error("write enable low in read");
  chk_wr_overlap: assert property (!write_en_n |->
    !chip_sel_n && out_en_n && byte_data_bus_oe)
    else $error("write outside select");
  chk_no_contend: assert property (!out_en_n |-> !byte_data_bus_oe)
    else $error("bus driven in read");
  chk_we_width: assert property ($rose(write_en_n) |-> we_lo >= WR_CYC)
    else $error("write pulse short");
  chk_wr_hold: assert property (!write_en_n |=>
    $stable(word_address) && $stable(byte_data_bus_o))
    else $error("address or data moved in write");
  chk_cycle_len: assert property ($fell(chip_sel_n) |->
    !chip_sel_n ##1 $stable(word_address))
    else $error("cycle too short");
  chk_rd_answer: assert property (s_rd_take |-> ##2 rsp_valid)
    else $error("read answer late");
  chk_rd_data: assert property (rsp_valid |->
    rsp_rdata == $past(byte_data_bus_i))
    else $error("read data not from pins");
  chk_wr_ready: assert property (req_valid && req_ready && req_write
    |=> s_wr_busy)
    else $error("write length wrong");
endmodule : asrm_properties
bind asrm_ctrl asrm_properties #(.WR_CYC(WR_CYC)) u_asrm_properties (
  .mclk, .sys_rst, .req_valid, .req_write, .req_ready, .rsp_valid,
  .rsp_rdata, .word_address, .chip_sel_n, .out_en_n, .write_en_n,
  .byte_data_bus_i, .byte_data_bus_o, .byte_data_bus_oe);

/* File: asrm_sram_model.sv */
/*
  Behavioural 32K x 8 static memory on the controller pins.
  Assumes the bench resolves the shared data pins.
*/
`timescale 1ns/100ps
module asrm_sram_model #(
  parameter int ACC_NS = 15
) (
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic [14:0] word_address,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic drive
);
  logic [7:0] mem [0:32767];
  logic wr_act;
  assign wr_act = !chip_sel_n && !write_en_n;
  // data taken at the end of the overlap, as late as possible
  always @(negedge wr_act) begin
    mem[word_address] = data_in;
  end
  assign drive = !chip_sel_n && !out_en_n && write_en_n;
  assign #ACC_NS data_out = mem[word_address];
endmodule : asrm_sram_model

/* File: asrm_ctrl_tb_top.sv */
/*
  Self-checking bench: controller against the memory model.
  Assumes default controller timing parameters.
*/
`timescale 1ns/100ps
module asrm_ctrl_tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [14:0] req_addr = 15'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, chip_sel_n, out_en_n, write_en_n;
  logic ctl_oe, mem_drv;
  logic [7:0] rsp_rdata, ctl_o, mem_o, bus;
  logic [7:0] last = 8'h00;
  logic [14:0] word_address;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  always #10 mclk = ~mclk;
  // a released bus shows the inverse of the last driven byte
  assign bus = ctl_oe ? ctl_o : (mem_drv ? mem_o : ~last);
  always @(posedge mclk) begin
    if (ctl_oe || mem_drv) last <= bus;
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end
  asrm_ctrl u_asrm_ctrl (.mclk(mclk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .word_address(word_address),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .byte_data_bus_i(bus), .byte_data_bus_o(ctl_o),
    .byte_data_bus_oe(ctl_oe));
  asrm_sram_model u_asrm_sram_model (.chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n),
    .word_address(word_address), .data_in(bus), .data_out(mem_o),
    .drive(mem_drv));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic req(input logic w, input logic [14:0] a,
                     input logic [7:0] d);
    @(negedge mclk);
    while (req_ready !== 1'b1) @(negedge mclk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : req
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    req(1'b0, a, 8'h00);
    for (int i = 0; i < 6 && rsp_valid !== 1'b1; i++) @(negedge mclk);
    chk({15'h0000, rsp_valid}, 16'h0001);
    chk({8'h00, rsp_rdata}, {8'h00, exp});
    @(negedge mclk);
    chk({15'h0000, rsp_valid}, 16'h0000);
  endtask : rd
  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    chk({11'h000, chip_sel_n, out_en_n, write_en_n, ctl_oe, req_ready},
        16'h001D);
  endtask : t_reset
  task automatic t_edges();
    req(1'b1, 15'h0000, 8'hA5);
    req(1'b1, 15'h7FFF, 8'h5A);
    req(1'b1, 15'h4AAA, 8'h3C);
    chk({8'h00, u_asrm_sram_model.mem[15'h7FFF]}, 16'h005A);
    rd(15'h0000, 8'hA5);
    rd(15'h7FFF, 8'h5A);
    rd(15'h4AAA, 8'h3C);
  endtask : t_edges
  task automatic t_refused();
    req(1'b1, 15'h0200, 8'h22);
    req(1'b1, 15'h0100, 8'h11);
    @(negedge mclk);
    req_valid = 1'b1;
    req_addr = 15'h0200;
    req_wdata = 8'hEE;
    @(negedge mclk);
    req_valid = 1'b0;
    rd(15'h0200, 8'h22);
    req(1'b1, 15'h0200, 8'hC3);
    rd(15'h0200, 8'hC3);
  endtask : t_refused
  initial begin
    t_reset();
    t_edges();
    t_refused();
    t_reset();
    rd(15'h0100, 8'h11);
    test_done();
  end
endmodule : asrm_ctrl_tb_top
